// File: include/tfc_pkg.sv
// Summary of operation
// - Beam-crossing clock is the only time reference
// - Each sync signal passes its own programmable delay
// - Fanout drives five identical links, one spare
// - Fanout ties a cable wire; card senses it
// - Card with cable drives timing onto backplane
// - Card without cable tristates backplane timing outputs
// - Any card may act as crate distributor
// - Fanout rebroadcasts triggers, suspend, resume, resume-recording
// - Host orders go card, upstream, then rebroadcast
// - Two one-direction bit-serial pairs per crate
// - Fanout config written only by upstream commands
// - Each trigger source individually enabled
// - Qualified accept freezes history until resume-recording order
package tfc_pkg;

    localparam int N_LINKS = 5;
    localparam int PAY_W = 8;
    localparam int CNT_W = 4;
    localparam int DLY_W = 4;
    localparam int N_DLY = 3;
    localparam int LINE_LEN = 16;

    // Counter end values for frame payload and inter-frame gap
    localparam logic [CNT_W-1:0] PAY_LAST = 4'h7;
    localparam logic [CNT_W-1:0] GAP_BITS = 4'h2;
    localparam logic [CNT_W-1:0] GAP_LAST = 4'h1;

    // Downstream payload bit positions
    localparam int B_BX = 0;
    localparam int B_L1A = 1;
    localparam int B_MQ = 2;
    localparam int B_SELF = 3;
    localparam int B_SOFT = 4;
    localparam int B_SUSPEND = 5;
    localparam int B_RESUME = 6;
    localparam int B_RES_REC = 7;
    localparam int ORDERS_W = 5;

    // Upstream payload: op in top two bits, argument below
    localparam int OP_MSB = 7;
    localparam int OP_LSB = 6;
    localparam int ARG_W = 6;
    localparam logic [1:0] OP_IDLE = 2'h0;
    localparam logic [1:0] OP_ORDERS = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam int WADDR_MSB = 5;
    localparam int WADDR_LSB = 4;
    localparam int DLY_IDX_L1A = 0;
    localparam int DLY_IDX_MQ = 1;
    localparam int DLY_IDX_BX = 2;
    localparam logic [DLY_W-1:0] DLY_RESET = 4'h0;

    // Level the fanout holds on the detect wire; the card pulls the other way
    localparam logic TIE_LEVEL = 1'b0;

    // Card trigger enable bit positions
    localparam int EN_SELF = 0;
    localparam int EN_SOFT = 1;
    localparam int EN_L1A = 2;
    localparam int EN_MQ = 3;

    // Cable debounce time and the derived cycle count at 40 MHz
    localparam int CLK_PERIOD_NS = 25;
    localparam int DEBOUNCE_NS = 200;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [CNT_W-1:0] STABLE_LAST = CNT_W'(DEBOUNCE_CYC - 1);

    typedef enum logic [0:0] {RX_IDLE, RX_DATA} tfc_rx_state_type;
    typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_GAP} tfc_tx_state_type;

endpackage : tfc_pkg

// File: include/tfc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// One serial pair each way per link plus the cable-detect wire
interface tfc_link_if #(parameter int N = tfc_pkg::N_LINKS);
    logic [N-1:0] down;
    logic [N-1:0] up;
    logic [N-1:0] tie;
    modport fanout (output down, output tie, input up);
    modport card (input down, input tie, output up);
endinterface : tfc_link_if
`default_nettype wire

// File: core/tfc_fanout.sv
`timescale 1ns/10ps
`default_nettype none
module tfc_fanout (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sync_bx,
    input wire logic sync_l1a,
    input wire logic sync_mq,
    tfc_link_if.fanout link
);
    localparam int N = tfc_pkg::N_LINKS;
    localparam int P = tfc_pkg::PAY_W;

    tfc_pkg::tfc_rx_state_type rx_st_reg [N];
    tfc_pkg::tfc_rx_state_type rx_st_next [N];
    logic [tfc_pkg::CNT_W-1:0] rx_cnt_reg [N];
    logic [tfc_pkg::CNT_W-1:0] rx_cnt_next [N];
    logic [P-1:0] rx_sh_reg [N];
    logic [P-1:0] rx_sh_next [N];
    logic [tfc_pkg::DLY_W-1:0] dly_reg [tfc_pkg::N_DLY];
    logic [tfc_pkg::DLY_W-1:0] dly_next [tfc_pkg::N_DLY];
    logic [tfc_pkg::LINE_LEN-1:0] line_reg [tfc_pkg::N_DLY];
    logic [tfc_pkg::LINE_LEN-1:0] line_next [tfc_pkg::N_DLY];
    logic [P-1:0] pend_reg;
    logic [P-1:0] pend_next;
    tfc_pkg::tfc_tx_state_type tx_st_reg;
    tfc_pkg::tfc_tx_state_type tx_st_next;
    logic [tfc_pkg::CNT_W-1:0] tx_cnt_reg;
    logic [tfc_pkg::CNT_W-1:0] tx_cnt_next;
    logic [P-1:0] tx_sh_reg;
    logic [P-1:0] tx_sh_next;
    logic down_reg;
    logic down_next;

    // Same serial stream on every link; the fifth is the spare
    assign link.down = {N{down_reg}};
    assign link.tie = {N{tfc_pkg::TIE_LEVEL}};

    // Receive upstream frames, collect orders and config writes
    always_comb begin
        logic [P-1:0] word;
        logic [tfc_pkg::ORDERS_W-1:0] orders;
        logic [P-1:0] events;
        word = '0;
        orders = '0;
        events = '0;
        dly_next = dly_reg;
        for (int i = N - 1; i >= 0; i--) begin
            rx_st_next[i] = rx_st_reg[i];
            rx_cnt_next[i] = rx_cnt_reg[i];
            rx_sh_next[i] = rx_sh_reg[i];
            word = {link.up[i], rx_sh_reg[i][P-1:1]};
            unique case (rx_st_reg[i])
                tfc_pkg::RX_IDLE: begin
                    if (link.up[i] && rx_cnt_reg[i] == tfc_pkg::GAP_BITS) begin
                        rx_st_next[i] = tfc_pkg::RX_DATA;
                        rx_cnt_next[i] = '0;
                    end else if (link.up[i]) begin
                        rx_cnt_next[i] = '0;
                    end else if (rx_cnt_reg[i] != tfc_pkg::GAP_BITS) begin
                        rx_cnt_next[i] = rx_cnt_reg[i] + 1'b1;
                    end
                end
                tfc_pkg::RX_DATA: begin
                    rx_sh_next[i] = word;
                    rx_cnt_next[i] = rx_cnt_reg[i] + 1'b1;
                    if (rx_cnt_reg[i] == tfc_pkg::PAY_LAST) begin
                        rx_st_next[i] = tfc_pkg::RX_IDLE;
                        rx_cnt_next[i] = '0;
                        if (word[tfc_pkg::OP_MSB:tfc_pkg::OP_LSB] == tfc_pkg::OP_ORDERS) begin
                            orders = orders | word[tfc_pkg::ORDERS_W-1:0];
                        end
                        // Lower link index wins when two crates write at once
                        if (word[tfc_pkg::OP_MSB:tfc_pkg::OP_LSB] == tfc_pkg::OP_WRITE
                            && int'(word[tfc_pkg::WADDR_MSB:tfc_pkg::WADDR_LSB])
                            < tfc_pkg::N_DLY) begin
                            dly_next[word[tfc_pkg::WADDR_MSB:tfc_pkg::WADDR_LSB]] =
                                word[tfc_pkg::DLY_W-1:0];
                        end
                    end
                end
            endcase
        end
        // Each sync signal runs down its own tapped line
        for (int d = 0; d < tfc_pkg::N_DLY; d++) begin
            line_next[d] = line_reg[d] << 1;
        end
        line_next[tfc_pkg::DLY_IDX_L1A][0] = sync_l1a;
        line_next[tfc_pkg::DLY_IDX_MQ][0] = sync_mq;
        line_next[tfc_pkg::DLY_IDX_BX][0] = sync_bx;
        events[tfc_pkg::B_L1A] = line_reg[tfc_pkg::DLY_IDX_L1A][dly_reg[tfc_pkg::DLY_IDX_L1A]];
        events[tfc_pkg::B_MQ] = line_reg[tfc_pkg::DLY_IDX_MQ][dly_reg[tfc_pkg::DLY_IDX_MQ]];
        events[tfc_pkg::B_BX] = line_reg[tfc_pkg::DLY_IDX_BX][dly_reg[tfc_pkg::DLY_IDX_BX]];
        events[tfc_pkg::B_RES_REC:tfc_pkg::B_SELF] = orders;
        // Pulses are held until a frame takes them; a new one beats the clear
        pend_next = pend_reg | events;
        tx_st_next = tx_st_reg;
        tx_cnt_next = tx_cnt_reg;
        tx_sh_next = tx_sh_reg;
        down_next = 1'b0;
        unique case (tx_st_reg)
            tfc_pkg::TX_IDLE: begin
                if (pend_reg != '0) begin
                    down_next = 1'b1;
                    tx_sh_next = pend_reg;
                    pend_next = events;
                    tx_cnt_next = '0;
                    tx_st_next = tfc_pkg::TX_DATA;
                end
            end
            tfc_pkg::TX_DATA: begin
                down_next = tx_sh_reg[0];
                tx_sh_next = tx_sh_reg >> 1;
                tx_cnt_next = tx_cnt_reg + 1'b1;
                if (tx_cnt_reg == tfc_pkg::PAY_LAST) begin
                    tx_cnt_next = '0;
                    tx_st_next = tfc_pkg::TX_GAP;
                end
            end
            tfc_pkg::TX_GAP: begin
                tx_cnt_next = tx_cnt_reg + 1'b1;
                if (tx_cnt_reg == tfc_pkg::GAP_LAST) begin
                    tx_cnt_next = '0;
                    tx_st_next = tfc_pkg::TX_IDLE;
                end
            end
        endcase
    end

    // Registers of the fanout end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                rx_st_reg[i] <= tfc_pkg::RX_IDLE;
                rx_cnt_reg[i] <= '0;
                rx_sh_reg[i] <= '0;
            end
            for (int d = 0; d < tfc_pkg::N_DLY; d++) begin
                dly_reg[d] <= tfc_pkg::DLY_RESET;
                line_reg[d] <= '0;
            end
            pend_reg <= '0;
            tx_st_reg <= tfc_pkg::TX_IDLE;
            tx_cnt_reg <= '0;
            tx_sh_reg <= '0;
            down_reg <= 1'b0;
        end else begin
            rx_st_reg <= rx_st_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_sh_reg <= rx_sh_next;
            dly_reg <= dly_next;
            line_reg <= line_next;
            pend_reg <= pend_next;
            tx_st_reg <= tx_st_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_sh_reg <= tx_sh_next;
            down_reg <= down_next;
        end
    end

endmodule : tfc_fanout
`default_nettype wire

// File: core/tfc_card.sv
`timescale 1ns/10ps
`default_nettype none
module tfc_card #(
    parameter int LINK = 0
) (
    input wire logic clk,
    input wire logic rst_n,
    tfc_link_if.card link,
    input wire logic host_valid,
    input wire logic [1:0] host_op,
    input wire logic [tfc_pkg::ARG_W-1:0] host_arg,
    output logic host_ready,
    input wire logic [tfc_pkg::PAY_W-1:0] bp_i,
    output logic [tfc_pkg::PAY_W-1:0] bp_o,
    output logic [tfc_pkg::PAY_W-1:0] bp_oe,
    input wire logic [3:0] trig_en,
    output logic trig_pulse,
    output logic rec_frozen,
    output logic run_suspended,
    output logic cable_ok
);
    localparam int P = tfc_pkg::PAY_W;

    // Refuse a link index that the link vector cannot serve
    if (LINK < 0 || LINK >= tfc_pkg::N_LINKS) begin : g_link_check
        $error("LINK index outside the link vector");
    end

    // Cable detect state
    logic tie_s1_reg;
    logic tie_s2_reg;
    logic [tfc_pkg::CNT_W-1:0] stab_cnt_reg;
    logic [tfc_pkg::CNT_W-1:0] stab_cnt_next;
    logic cable_ok_reg;
    logic cable_ok_next;
    // Downstream receiver
    tfc_pkg::tfc_rx_state_type rx_st_reg;
    tfc_pkg::tfc_rx_state_type rx_st_next;
    logic [tfc_pkg::CNT_W-1:0] rx_cnt_reg;
    logic [tfc_pkg::CNT_W-1:0] rx_cnt_next;
    logic [P-1:0] rx_sh_reg;
    logic [P-1:0] rx_sh_next;
    logic [P-1:0] bp_o_reg;
    logic [P-1:0] bp_o_next;
    logic [P-1:0] bp_oe_reg;
    logic [P-1:0] bp_oe_next;
    // Upstream transmitter
    tfc_pkg::tfc_tx_state_type tx_st_reg;
    tfc_pkg::tfc_tx_state_type tx_st_next;
    logic [tfc_pkg::CNT_W-1:0] tx_cnt_reg;
    logic [tfc_pkg::CNT_W-1:0] tx_cnt_next;
    logic [P-1:0] tx_sh_reg;
    logic [P-1:0] tx_sh_next;
    logic up_reg;
    logic up_next;
    logic host_ready_reg;
    logic host_ready_next;
    // Trigger and recording control
    logic trig_pulse_reg;
    logic trig_pulse_next;
    logic rec_frozen_reg;
    logic rec_frozen_next;
    logic run_suspended_reg;
    logic run_suspended_next;

    // Every card carries the full distributor logic; the cable picks the active one
    assign link.up[LINK] = up_reg;
    assign host_ready = host_ready_reg;
    assign bp_o = bp_o_reg;
    assign bp_oe = bp_oe_reg;
    assign trig_pulse = trig_pulse_reg;
    assign rec_frozen = rec_frozen_reg;
    assign run_suspended = run_suspended_reg;
    assign cable_ok = cable_ok_reg;

    // Debounce: the detect level must disagree for the full window to flip
    always_comb begin
        logic seen;
        seen = (tie_s2_reg == tfc_pkg::TIE_LEVEL);
        stab_cnt_next = '0;
        cable_ok_next = cable_ok_reg;
        if (seen != cable_ok_reg) begin
            stab_cnt_next = stab_cnt_reg + 1'b1;
            if (stab_cnt_reg == tfc_pkg::STABLE_LAST) begin
                cable_ok_next = seen;
                stab_cnt_next = '0;
            end
        end
    end

    // Two flops before anyone looks at the detect wire
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tie_s1_reg <= ~tfc_pkg::TIE_LEVEL;
            tie_s2_reg <= ~tfc_pkg::TIE_LEVEL;
            stab_cnt_reg <= '0;
            cable_ok_reg <= 1'b0;
        end else begin
            tie_s1_reg <= link.tie[LINK];
            tie_s2_reg <= tie_s1_reg;
            stab_cnt_reg <= stab_cnt_next;
            cable_ok_reg <= cable_ok_next;
        end
    end

    // Downstream frame receiver and backplane drive
    always_comb begin
        logic [P-1:0] word;
        word = {link.down[LINK], rx_sh_reg[P-1:1]};
        rx_st_next = rx_st_reg;
        rx_cnt_next = rx_cnt_reg;
        rx_sh_next = rx_sh_reg;
        bp_o_next = '0;
        unique case (rx_st_reg)
            tfc_pkg::RX_IDLE: begin
                if (link.down[LINK] && rx_cnt_reg == tfc_pkg::GAP_BITS) begin
                    rx_st_next = tfc_pkg::RX_DATA;
                    rx_cnt_next = '0;
                end else if (link.down[LINK]) begin
                    rx_cnt_next = '0;
                end else if (rx_cnt_reg != tfc_pkg::GAP_BITS) begin
                    rx_cnt_next = rx_cnt_reg + 1'b1;
                end
            end
            tfc_pkg::RX_DATA: begin
                rx_sh_next = word;
                rx_cnt_next = rx_cnt_reg + 1'b1;
                if (rx_cnt_reg == tfc_pkg::PAY_LAST) begin
                    rx_st_next = tfc_pkg::RX_IDLE;
                    rx_cnt_next = '0;
                    if (cable_ok_reg) begin
                        bp_o_next = word;
                    end
                end
            end
        endcase
        // Drivers follow the debounced detect; off means high impedance
        bp_oe_next = {P{cable_ok_reg}};
    end

    // Receiver registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_reg <= tfc_pkg::RX_IDLE;
            rx_cnt_reg <= '0;
            rx_sh_reg <= '0;
            bp_o_reg <= '0;
            bp_oe_reg <= '0;
        end else begin
            rx_st_reg <= rx_st_next;
            rx_cnt_reg <= rx_cnt_next;
            rx_sh_reg <= rx_sh_next;
            bp_o_reg <= bp_o_next;
            bp_oe_reg <= bp_oe_next;
        end
    end

    // Host commands go upstream only from the card that holds the cable
    always_comb begin
        tx_st_next = tx_st_reg;
        tx_cnt_next = tx_cnt_reg;
        tx_sh_next = tx_sh_reg;
        up_next = 1'b0;
        unique case (tx_st_reg)
            tfc_pkg::TX_IDLE: begin
                if (host_valid && host_ready_reg && host_op != tfc_pkg::OP_IDLE) begin
                    up_next = 1'b1;
                    tx_sh_next = {host_op, host_arg};
                    tx_cnt_next = '0;
                    tx_st_next = tfc_pkg::TX_DATA;
                end
            end
            tfc_pkg::TX_DATA: begin
                up_next = tx_sh_reg[0];
                tx_sh_next = tx_sh_reg >> 1;
                tx_cnt_next = tx_cnt_reg + 1'b1;
                if (tx_cnt_reg == tfc_pkg::PAY_LAST) begin
                    tx_cnt_next = '0;
                    tx_st_next = tfc_pkg::TX_GAP;
                end
            end
            tfc_pkg::TX_GAP: begin
                tx_cnt_next = tx_cnt_reg + 1'b1;
                if (tx_cnt_reg == tfc_pkg::GAP_LAST) begin
                    tx_cnt_next = '0;
                    tx_st_next = tfc_pkg::TX_IDLE;
                end
            end
        endcase
        host_ready_next = (tx_st_next == tfc_pkg::TX_IDLE) && cable_ok_next;
    end

    // Transmitter registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_st_reg <= tfc_pkg::TX_IDLE;
            tx_cnt_reg <= '0;
            tx_sh_reg <= '0;
            up_reg <= 1'b0;
            host_ready_reg <= 1'b0;
        end else begin
            tx_st_reg <= tx_st_next;
            tx_cnt_reg <= tx_cnt_next;
            tx_sh_reg <= tx_sh_next;
            up_reg <= up_next;
            host_ready_reg <= host_ready_next;
        end
    end

    // Trigger acceptance and history freeze, from what the backplane carries
    always_comb begin
        logic self_t;
        logic soft_t;
        logic l1a_t;
        logic qual_t;
        self_t = bp_i[tfc_pkg::B_SELF] && trig_en[tfc_pkg::EN_SELF];
        soft_t = bp_i[tfc_pkg::B_SOFT] && trig_en[tfc_pkg::EN_SOFT];
        l1a_t = bp_i[tfc_pkg::B_L1A] && trig_en[tfc_pkg::EN_L1A];
        qual_t = bp_i[tfc_pkg::B_MQ] && trig_en[tfc_pkg::EN_MQ];
        trig_pulse_next = self_t || soft_t || l1a_t;
        // Freeze wins over a resume arriving in the same cycle
        rec_frozen_next = rec_frozen_reg;
        if (bp_i[tfc_pkg::B_RES_REC]) begin
            rec_frozen_next = 1'b0;
        end
        if ((l1a_t && qual_t) || soft_t) begin
            rec_frozen_next = 1'b1;
        end
        run_suspended_next = run_suspended_reg;
        if (bp_i[tfc_pkg::B_RESUME]) begin
            run_suspended_next = 1'b0;
        end
        if (bp_i[tfc_pkg::B_SUSPEND]) begin
            run_suspended_next = 1'b1;
        end
    end

    // Trigger and recording registers, all on the beam-crossing clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_pulse_reg <= 1'b0;
            rec_frozen_reg <= 1'b0;
            run_suspended_reg <= 1'b0;
        end else begin
            trig_pulse_reg <= trig_pulse_next;
            rec_frozen_reg <= rec_frozen_next;
            run_suspended_reg <= run_suspended_next;
        end
    end

endmodule : tfc_card
`default_nettype wire

// File: test/tfc_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module tfc_link_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [tfc_pkg::N_LINKS-1:0] down,
    input wire logic [tfc_pkg::N_LINKS-1:0] up,
    input wire logic [tfc_pkg::N_LINKS-1:0] tie
);
    logic [3:0] dpos_reg, dpos_next, upos_reg, upos_next;
    logic [7:0] ush_reg, ush_next;
    // Frame position on link 0 each way; 9 and 10 are the gap bits
    always_comb begin
        dpos_next = (dpos_reg == 4'h0) ? {3'h0, down[0]} : dpos_reg + 4'h1;
        upos_next = (upos_reg == 4'h0) ? {3'h0, up[0]} : upos_reg + 4'h1;
        if (dpos_reg == 4'ha) dpos_next = 4'h0;
        if (upos_reg == 4'ha) upos_next = 4'h0;
        ush_next = (upos_reg != 4'h0 && upos_reg < 4'h9) ? {up[0], ush_reg[7:1]} : ush_reg;
    end
    // Trackers share the link reset so a frame never straddles it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dpos_reg <= 4'h0;
            upos_reg <= 4'h0;
            ush_reg <= 8'h00;
        end else begin
            dpos_reg <= dpos_next;
            upos_reg <= upos_next;
            ush_reg <= ush_next;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_tie; tie == {tfc_pkg::N_LINKS{tfc_pkg::TIE_LEVEL}}; endproperty
    a_tie: assert property (p_tie) else $error("detect wire off its level");
    property p_same; down == {tfc_pkg::N_LINKS{down[0]}}; endproperty
    a_same: assert property (p_same) else $error("downlinks differ");
    property p_dgap; dpos_reg > 4'h8 |-> !down[0]; endproperty
    a_dgap: assert property (p_dgap) else $error("downlink gap broken");
    property p_ugap; upos_reg > 4'h8 |-> !up[0]; endproperty
    a_ugap: assert property (p_ugap) else $error("uplink gap broken");
    property p_dpre; dpos_reg == 4'h0 && down[0] |-> !$past(down[0]) && !$past(down[0], 2);
    endproperty
    a_dpre: assert property (p_dpre) else $error("downlink start too soon");
    property p_upre; upos_reg == 4'h0 && up[0] |-> !$past(up[0]) && !$past(up[0], 2); endproperty
    a_upre: assert property (p_upre) else $error("uplink start too soon");
    property p_idle; $rose(rst_n) |-> ~|down ##1 ~|down; endproperty
    a_idle: assert property (p_idle) else $error("downlink not idle after reset");
    property p_fwd;
        upos_reg == 4'h9 && ush_reg[7:6] == tfc_pkg::OP_ORDERS && |ush_reg[4:0]
            |-> ##[0:16] (dpos_reg == 4'h0 && down[0]);
    endproperty
    a_fwd: assert property (p_fwd) else $error("order not rebroadcast");
endmodule : tfc_link_sva
`default_nettype wire

// File: test/timing_fanout_command_link_bench.sv
`timescale 1ns/10ps
`default_nettype none
module timing_fanout_command_link_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sync_bx = 1'b0;
    logic sync_l1a = 1'b0;
    logic sync_mq = 1'b0;
    logic host_valid = 1'b0;
    logic [1:0] host_op = 2'h0;
    logic [5:0] host_arg = 6'h00;
    logic [3:0] trig_en = 4'h0;
    logic host_ready, ready_nc, trig_pulse, pulse_nc, rec_frozen, frozen_nc;
    logic run_suspended, susp_nc, cable_ok, cable_nc;
    logic [7:0] bp_o, bp_oe, bpo_nc, bpoe_nc, bp, last_bp, v;
    int err_count = 0;
    int tests_run = 0;
    int n_trig = 0;
    int n_trig_nc = 0;
    int n_bp = 0;
    int froz_m = 0;
    int susp_m = 0;
    int w, base, d;
    tfc_link_if link_if ();
    tfc_link_if link_nc ();
    // Unused crate uplinks idle; the uncabled card sees its own pull-up
    assign link_if.up[4:1] = 4'h0;
    assign link_nc.tie = 5'h1f;
    assign link_nc.down = 5'h00;
    // One crate backplane: enabled drivers OR together, pulled low otherwise
    assign bp = (bp_o & bp_oe) | (bpo_nc & bpoe_nc);
    always #12.5 clk = ~clk;
    tfc_fanout tfc_fanout_inst (.clk(clk), .rst_n(rst_n), .sync_bx(sync_bx),
        .sync_l1a(sync_l1a), .sync_mq(sync_mq), .link(link_if.fanout));
    tfc_card #(.LINK(0)) tfc_card_inst (.clk(clk), .rst_n(rst_n), .link(link_if.card),
        .host_valid(host_valid), .host_op(host_op), .host_arg(host_arg),
        .host_ready(host_ready), .bp_i(bp), .bp_o(bp_o), .bp_oe(bp_oe), .trig_en(trig_en),
        .trig_pulse(trig_pulse), .rec_frozen(rec_frozen), .run_suspended(run_suspended),
        .cable_ok(cable_ok));
    tfc_card #(.LINK(0)) tfc_card_nc_inst (.clk(clk), .rst_n(rst_n), .link(link_nc.card),
        .host_valid(1'b1), .host_op(tfc_pkg::OP_ORDERS), .host_arg(6'h1f),
        .host_ready(ready_nc), .bp_i(bp), .bp_o(bpo_nc), .bp_oe(bpoe_nc), .trig_en(trig_en),
        .trig_pulse(pulse_nc), .rec_frozen(frozen_nc), .run_suspended(susp_nc),
        .cable_ok(cable_nc));
    tfc_link_sva tfc_link_sva_inst (.clk(clk), .rst_n(rst_n), .down(link_if.down),
        .up(link_if.up), .tie(link_if.tie));
    // Latches backplane pulses and counts trigger pulses of both cards
    always @(posedge clk) begin
        if (bp_o != 8'h00) begin
            last_bp <= bp_o;
            n_bp <= n_bp + 1;
        end
        n_trig <= n_trig + int'(trig_pulse);
        n_trig_nc <= n_trig_nc + int'(pulse_nc);
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask : check
    task summarize;
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // Waits a bounded time for a start bit, then gathers the byte LSB first
    task get_frame(input bit upl, output logic [7:0] val, output int waited);
        waited = 0;
        #1;
        while ((upl ? link_if.up[0] : link_if.down[0]) !== 1'b1 && waited < 300) begin
            @(posedge clk);
            #1;
            waited++;
        end
        check(8'(waited < 300), 8'h01);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            #1;
            val[i] = upl ? link_if.up[0] : link_if.down[0];
        end
    endtask : get_frame
    // Host command; waits for ready, then holds valid for one cycle
    task send(input logic [1:0] op, input logic [5:0] arg);
        int k;
        k = 0;
        while (host_ready !== 1'b1 && k < 100) begin
            @(posedge clk);
            #1;
            k++;
        end
        @(posedge clk);
        host_valid <= 1'b1;
        host_op <= op;
        host_arg <= arg;
        @(posedge clk);
        host_valid <= 1'b0;
        get_frame(1'b1, v, w);
        check(v, {op, arg});
    endtask : send
    // Order round trip through uplink, rebroadcast, backplane and trigger logic
    task orders(input logic [4:0] arg, input logic [3:0] en);
        int ex, b0, t0, t1;
        @(posedge clk);
        trig_en <= en;
        send(tfc_pkg::OP_ORDERS, {1'b0, arg});
        get_frame(1'b0, v, w);
        check(v, {arg, 3'h0});
        b0 = n_bp;
        t0 = n_trig;
        t1 = n_trig_nc;
        repeat (6) @(posedge clk);
        #1;
        ex = (arg[0] & en[0]) | (arg[1] & en[1]);
        froz_m = (arg[1] & en[1]) ? 1 : (arg[4] ? 0 : froz_m);
        susp_m = arg[2] ? 1 : (arg[3] ? 0 : susp_m);
        check(last_bp, {arg, 3'h0});
        check(8'(n_bp - b0), 8'h01);
        check(8'(n_trig - t0), 8'(ex));
        check(8'(n_trig_nc - t1), 8'(ex));
        check({rec_frozen, frozen_nc}, {2{froz_m[0]}});
        check({run_suspended, susp_nc}, {2{susp_m[0]}});
    endtask : orders
    // Sync pulse, m bit 0 l1a, bit 1 mq, bit 2 bx; returns frame latency
    task pulse(input logic [2:0] m, output int waited);
        @(posedge clk);
        {sync_bx, sync_mq, sync_l1a} <= m;
        @(posedge clk);
        {sync_bx, sync_mq, sync_l1a} <= 3'h0;
        get_frame(1'b0, v, waited);
        check(v, {5'h00, m[1], m[0], m[2]});
    endtask : pulse
    initial begin
        void'($urandom(51992));
        repeat (4) @(posedge clk);
        #1;
        check({host_ready, cable_ok, link_if.down[0], link_if.up[0]}, 8'h00);
        check(bp_oe, 8'h00);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check(cable_ok, 1'b0);
        w = 0;
        while (cable_ok !== 1'b1 && w < 40) begin
            @(posedge clk);
            #1;
            w++;
        end
        // Drivers enable one cycle after the debounced detect
        @(posedge clk);
        #1;
        check(link_if.tie[0], tfc_pkg::TIE_LEVEL);
        check(bp_oe, 8'hff);
        check(bpoe_nc, 8'h00);
        check(cable_nc, 1'b0);
        for (int i = 0; i < 10; i++) begin
            orders(i < 5 ? 5'(1 << i) : 5'($urandom_range(1, 31)), 4'($urandom));
        end
        // Each delay index: latency grows by the tap; index 3 writes are dropped
        for (int i = 0; i < 3; i++) begin
            send(tfc_pkg::OP_WRITE, {2'(i), 4'h0});
            pulse(3'(1 << i), base);
            d = $urandom_range(1, 15);
            send(tfc_pkg::OP_WRITE, {2'(i), 4'(d)});
            pulse(3'(1 << i), w);
            check(8'(w - base), 8'(d));
            send(tfc_pkg::OP_WRITE, {2'h3, 4'h9});
            pulse(3'(1 << i), w);
            check(8'(w - base), 8'(d));
        end
        // Qualified accept: equal delays put accept and qualifier in one frame
        orders(5'h10, 4'hc);
        send(tfc_pkg::OP_WRITE, {2'h0, 4'h0});
        send(tfc_pkg::OP_WRITE, {2'h1, 4'h0});
        base = n_trig;
        pulse(3'h3, w);
        repeat (6) @(posedge clk);
        #1;
        check({rec_frozen, frozen_nc}, 8'h03);
        check(8'(n_trig - base), 8'h01);
        froz_m = 1;
        orders(5'h10, 4'hc);
        // An idle op with valid high must not start a frame
        @(posedge clk);
        host_valid <= 1'b1;
        host_op <= tfc_pkg::OP_IDLE;
        repeat (3) @(posedge clk);
        #1;
        check(host_ready, 1'b1);
        check(ready_nc, 1'b0);
        check(link_nc.up[0], 1'b0);
        summarize();
    end
    // Watchdog at 8000 cycles, well beyond the several hundred cycles the sequence needs
    initial begin
        #200000;
        err_count++;
        summarize();
    end
endmodule : timing_fanout_command_link_bench
`default_nettype wire
